// ==== logic/uv_fault_response.sv ====
// output under-voltage fault detection and response sequencer
`timescale 1ns/10ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// What this block does
// - The fault threshold is kept as a 16-bit unsigned value, exponent -11.
// - Response 00 leaves the output running through a fault.
// - Response 01 runs on for the delay, then applies the retry setting.
// - Response 10 disables the output at once, then applies the retry setting.
// - Response 11 holds the output off only while the fault persists.
// - A latched fault clears on status clear, clear-all, reset or off-then-on.
// - The retry field sets the restart count; 111 restarts without limit.
// - Retry 000 makes no restart and stays off until cleared.
// - Retry 001 makes one restart, then stays off until cleared if it fails.
// - Restarts are spaced by two to the delay code times the delay unit.
// - Retry 010 to 110 make two to six restarts before latching off.
// - Retry 111 restarts until commanded off or the fault clears during a restart.
// - Delay code n means two to the n time units.
// - The delay unit comes from a separate configuration register.
module uv_fault_response
    import uv_fault_pkg::*;
#(
    parameter int UNIT_CYCLES_W = uv_fault_pkg::UNIT_WIDTH
) (
    input  wire logic                      clk,
    input  wire logic                      sys_rst,
    input  wire uv_fault_pkg::host_write_s hostWrite,
    input  wire uv_fault_pkg::clear_s      clearReq,
    input  wire logic [15:0]               voutMeasured,
    input  wire logic [UNIT_CYCLES_W-1:0]  delayUnitCycles,
    output logic [15:0]                    thresholdOut,
    output logic [7:0]                     actionOut,
    output logic                           outputEnable,
    output logic                           uvFaultStatus,
    output logic                           uvFaultActive
);
    import uv_fault_pkg::*;

    // delay code n gives 2**n units, units given in clock cycles
    function automatic logic [DELAY_WIDTH-1:0] delayCycles(
        input logic [2:0]               code,
        input logic [UNIT_CYCLES_W-1:0] unitCycles
    );
        logic [DELAY_WIDTH-1:0] wide;
        wide = DELAY_WIDTH'(unitCycles);
        return wide << code;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    logic [15:0]            thresholdReg, thresholdNext;
    logic [7:0]             actionReg, actionNext;
    state_e                 stateReg, stateNext;
    logic [DELAY_WIDTH-1:0] timerReg, timerNext;
    logic [2:0]             triesReg, triesNext;
    logic                   statusReg, statusNext;
    logic                   enableReg, enableNext;
    logic                   onPrevReg, onPrevNext;
    logic                   activeReg, activeNext;
    logic                   faultNow;
    logic                   onRestart;
    logic                   clearLatch;
    logic [1:0]             resp;
    logic [2:0]             retrySet;
    logic [DELAY_WIDTH-1:0] spacing;

    assign faultNow   = voutMeasured < thresholdReg;
    assign onRestart  = clearReq.outputOnCmd & ~onPrevReg;
    assign clearLatch = clearReq.clearStatus | clearReq.clearFaults
                      | clearReq.faultReset | onRestart;
    assign resp       = actionReg[RESP_HI:RESP_LO];
    assign retrySet   = actionReg[RETRY_HI:RETRY_LO];
    // unit read live so a changed unit register applies at the next delay
    assign spacing    = delayCycles(actionReg[DELAY_HI:DELAY_LO],
                                    delayUnitCycles);

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        thresholdNext = thresholdReg;
        actionNext    = actionReg;
        if (hostWrite.write && hostWrite.command == CMD_THRESHOLD) begin
            thresholdNext = hostWrite.data;
        end
        if (hostWrite.write && hostWrite.command == CMD_ACTION) begin
            actionNext = hostWrite.data[7:0];
        end
    end

    always_comb begin
        stateNext  = stateReg;
        timerNext  = timerReg;
        triesNext  = triesReg;
        enableNext = enableReg;
        onPrevNext = clearReq.outputOnCmd;
        // set wins over clear while the fault is still present
        statusNext = faultNow | (statusReg & ~clearLatch);
        if (timerReg != '0) begin
            timerNext = timerReg - DELAY_WIDTH'(1);
        end
        unique case (stateReg)
            ST_RUN: begin
                enableNext = 1'b1;
                triesNext  = '0;
                if (faultNow) begin
                    unique case (resp)
                        RESP_IGNORE: stateNext = ST_RUN;
                        RESP_DELAYED: begin
                            stateNext = ST_GRACE;
                            timerNext = spacing;
                        end
                        RESP_SHUTDOWN: begin
                            enableNext = 1'b0;
                            stateNext  = ST_OFF_WAIT;
                            timerNext  = spacing;
                        end
                        RESP_WHILE: begin
                            enableNext = 1'b0;
                            stateNext  = ST_HOLD_OFF;
                        end
                    endcase
                end
            end
            ST_GRACE: begin
                if (!faultNow) begin
                    stateNext = ST_RUN;
                end else if (timerReg == '0) begin
                    enableNext = 1'b0;
                    stateNext  = ST_OFF_WAIT;
                    // spacing already ran from the attempt start
                    timerNext  = '0;
                end
            end
            ST_OFF_WAIT: begin
                enableNext = 1'b0;
                if (retrySet == RETRY_NONE) begin
                    stateNext = ST_LATCHED;
                end else if (timerReg == '0) begin
                    // restart attempt; a fault lasting through its whole delay counts as failure
                    // >= so a lowered retry setting still latches off
                    if (retrySet != RETRY_FOREVER && triesReg >= retrySet) begin
                        stateNext = ST_LATCHED;
                    end else begin
                        enableNext = 1'b1;
                        stateNext  = ST_GRACE;
                        timerNext  = spacing;
                        if (retrySet != RETRY_FOREVER) begin
                            triesNext = triesReg + 3'h1;
                        end
                    end
                end
            end
            ST_HOLD_OFF: begin
                enableNext = 1'b0;
                if (!faultNow) begin
                    enableNext = 1'b1;
                    stateNext  = ST_RUN;
                end
            end
            ST_LATCHED: begin
                enableNext = 1'b0;
                if (clearLatch) begin
                    stateNext  = ST_RUN;
                    enableNext = 1'b1;
                end
            end
            default: stateNext = ST_RUN;
        endcase
        if (!clearReq.outputOnCmd) begin
            // commanded off ends any retry sequence
            stateNext  = ST_RUN;
            enableNext = 1'b0;
            timerNext  = '0;
        end
        activeNext = (stateNext != ST_RUN);
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            thresholdReg <= THRESHOLD_RESET;
            actionReg    <= ACTION_RESET;
            stateReg     <= ST_RUN;
            timerReg     <= '0;
            triesReg     <= '0;
            statusReg    <= 1'b0;
            enableReg    <= 1'b0;
            onPrevReg    <= 1'b0;
            activeReg    <= 1'b0;
        end else begin
            thresholdReg <= thresholdNext;
            actionReg    <= actionNext;
            stateReg     <= stateNext;
            timerReg     <= timerNext;
            triesReg     <= triesNext;
            statusReg    <= statusNext;
            enableReg    <= enableNext;
            onPrevReg    <= onPrevNext;
            activeReg    <= activeNext;
        end
    end

    assign thresholdOut  = thresholdReg;
    assign actionOut     = actionReg;
    assign outputEnable  = enableReg;
    assign uvFaultStatus = statusReg;
    assign uvFaultActive = activeReg;

    ////////////////////////////////////////////////////////////////////////////
    AST_IGNORE_KEEPS_ON: assert property (@(posedge clk) disable iff (sys_rst)
        (stateReg == ST_RUN && resp == RESP_IGNORE && clearReq.outputOnCmd
         && enableReg) |=> enableReg)
        else $error("ignore response dropped the output");
    AST_SHUTDOWN_NOW: assert property (@(posedge clk) disable iff (sys_rst)
        (stateReg == ST_RUN && faultNow && resp == RESP_SHUTDOWN)
        |=> !enableReg)
        else $error("shutdown response left the output on");
    AST_WHILE_RESUME: assert property (@(posedge clk) disable iff (sys_rst)
        (stateReg == ST_HOLD_OFF && !faultNow && clearReq.outputOnCmd)
        |=> enableReg && stateReg == ST_RUN)
        else $error("output not restored after fault went away");
    AST_STATUS_SET: assert property (@(posedge clk) disable iff (sys_rst)
        faultNow |=> statusReg)
        else $error("fault status flag not set");
    AST_STATUS_CLEAR: assert property (@(posedge clk) disable iff (sys_rst)
        (statusReg && clearReq.clearFaults && !faultNow)
        |=> !statusReg)
        else $error("status not cleared by clear faults");
    AST_NO_RETRY: assert property (@(posedge clk) disable iff (sys_rst)
        (stateReg == ST_OFF_WAIT && retrySet == RETRY_NONE
         && clearReq.outputOnCmd) |=> stateReg == ST_LATCHED)
        else $error("retry 000 did not latch off");
    AST_LATCH_STAYS_OFF: assert property (@(posedge clk) disable iff (sys_rst)
        (stateReg == ST_LATCHED && !clearLatch) |=> !enableReg)
        else $error("latched fault output came back on");
    AST_TRY_LIMIT: assert property (@(posedge clk) disable iff (sys_rst)
        (stateReg == ST_OFF_WAIT && retrySet != RETRY_FOREVER
         && triesReg >= retrySet) |=> !enableReg)
        else $error("too many restart attempts");
    AST_DELAY_LOAD: assert property (@(posedge clk) disable iff (sys_rst)
        (stateReg == ST_RUN && faultNow && resp == RESP_DELAYED
         && clearReq.outputOnCmd) |=> timerReg == $past(spacing))
        else $error("delay not loaded with decoded spacing");
endmodule

`default_nettype wire

// ==== shared/uv_fault_pkg.sv ====
// package: register map, fields and states of the output under-voltage fault block
package uv_fault_pkg;
    localparam logic [7:0]  CMD_THRESHOLD   = 8'h44;
    localparam logic [7:0]  CMD_ACTION      = 8'h45;
    localparam logic [15:0] THRESHOLD_RESET = 16'h0000;
    localparam logic [7:0]  ACTION_RESET    = 8'h00;
    localparam int          RESP_HI         = 7;
    localparam int          RESP_LO         = 6;
    localparam int          RETRY_HI        = 5;
    localparam int          RETRY_LO        = 3;
    localparam int          DELAY_HI        = 2;
    localparam int          DELAY_LO        = 0;
    localparam logic [1:0]  RESP_IGNORE     = 2'h0;
    localparam logic [1:0]  RESP_DELAYED    = 2'h1;
    localparam logic [1:0]  RESP_SHUTDOWN   = 2'h2;
    localparam logic [1:0]  RESP_WHILE      = 2'h3;
    localparam logic [2:0]  RETRY_NONE      = 3'h0;
    localparam logic [2:0]  RETRY_FOREVER   = 3'h7;
    localparam int          UNIT_WIDTH      = 16;
    localparam int          DELAY_WIDTH     = 24;

    typedef enum logic [2:0] {
        ST_RUN,
        ST_GRACE,
        ST_OFF_WAIT,
        ST_HOLD_OFF,
        ST_LATCHED
    } state_e;

    typedef struct packed {
        logic        write;
        logic [7:0]  command;
        logic [15:0] data;
    } host_write_s;

    typedef struct packed {
        logic clearStatus;
        logic clearFaults;
        logic faultReset;
        logic outputOnCmd;
    } clear_s;
endpackage

// ==== test/uv_fault_response_tb.sv ====
// self-checking bench for the under-voltage fault response block
`timescale 1ns/10ps
`default_nettype none

module uv_fault_response_tb;
    import uv_fault_pkg::*;

    logic        clk;
    logic        sys_rst;
    logic [15:0] voutMeasured;
    logic [15:0] delayUnitCycles;
    host_write_s hostWrite;
    clear_s      clearReq;
    logic [15:0] thresholdOut;
    logic [7:0]  actionOut;
    logic        outputEnable;
    logic        uvFaultStatus;
    logic        uvFaultActive;
    logic        prevOe;
    logic        countClear;
    logic        gapOk;
    int          nErrors = 0;
    int          cmpCount = 0;
    int          rises = 0;
    int          lastRise = 0;
    int          gapMin = 0;
    int          gapMax = 0;
    int          cyc = 0;
    int          unitNow;
    int          expSpacing;

    uv_fault_response dut (.clk(clk), .sys_rst(sys_rst), .hostWrite(hostWrite),
        .clearReq(clearReq), .voutMeasured(voutMeasured),
        .delayUnitCycles(delayUnitCycles), .thresholdOut(thresholdOut),
        .actionOut(actionOut), .outputEnable(outputEnable),
        .uvFaultStatus(uvFaultStatus), .uvFaultActive(uvFaultActive));
    uv_host_model host (.clk(clk), .hostWrite(hostWrite), .clearReq(clearReq));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////
    // restart counter; the first rise of a window is counted but opens no gap
    always @(posedge clk) begin
        cyc    <= cyc + 1;
        prevOe <= outputEnable;
        if (countClear === 1'b1) begin
            rises  <= 0;
            gapMin <= 999;
            gapMax <= 0;
        end else if (outputEnable === 1'b1 && prevOe === 1'b0) begin
            rises    <= rises + 1;
            lastRise <= cyc;
            if (rises > 0 && cyc - lastRise < gapMin) gapMin <= cyc - lastRise;
            if (rises > 0 && cyc - lastRise > gapMax) gapMax <= cyc - lastRise;
        end
    end

    task automatic check(input string what, input logic [15:0] exp,
                         input logic [15:0] got);
        cmpCount++;
        if (got !== exp) begin
            nErrors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic waitN(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic giveVerdict;
        $display("comparisons %0d mismatches %0d", cmpCount, nErrors);
        if (nErrors == 0 && cmpCount > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    // whole run is a few thousand cycles; this is far beyond it
    initial begin
        #100000;
        nErrors++;
        giveVerdict;
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        sys_rst = 1'b1;
        countClear = 1'b0;
        voutMeasured = 16'h8000;
        delayUnitCycles = 16'h0004;
        waitN(4);
        sys_rst = 1'b0;
        check("threshold reset", THRESHOLD_RESET, thresholdOut);
        check("action reset", 16'(ACTION_RESET), 16'(actionOut));
        check("enable reset", 16'h0000, 16'(outputEnable));
        check("active reset", 16'h0000, 16'(uvFaultActive));
        host.setOn(1'b1);
        waitN(3);
        check("enable on", 16'h0001, 16'(outputEnable));
        host.writeCmd(CMD_THRESHOLD, 16'h4000);
        host.writeCmd(8'h46, 16'hffff);
        host.writeCmd(CMD_ACTION, 16'hff00);
        waitN(1);
        check("threshold", 16'h4000, thresholdOut);
        check("action", 16'h0000, 16'(actionOut));
        voutMeasured = 16'h3fff;
        waitN(6);
        check("ignore enable", 16'h0001, 16'(outputEnable));
        check("ignore status", 16'h0001, 16'(uvFaultStatus));
        check("ignore active", 16'h0000, 16'(uvFaultActive));
        host.clearFault(0);
        check("status held", 16'h0001, 16'(uvFaultStatus));
        voutMeasured = 16'h4000;
        host.clearFault(0);
        waitN(1);
        check("status clear", 16'h0000, 16'(uvFaultStatus));
        host.writeCmd(CMD_ACTION, 16'h00c0);
        voutMeasured = 16'h1000;
        waitN(3);
        check("while enable", 16'h0000, 16'(outputEnable));
        check("while active", 16'h0001, 16'(uvFaultActive));
        voutMeasured = 16'h8000;
        waitN(3);
        check("while resume", 16'h0001, 16'(outputEnable));
        host.writeCmd(CMD_ACTION, 16'h0080);
        host.clearFault(1);
        voutMeasured = 16'h1000;
        waitN(3);
        check("shutdown", 16'h0000, 16'(outputEnable));
        voutMeasured = 16'h8000;
        waitN(40);
        check("latched", 16'h0000, 16'(outputEnable));
        check("latched active", 16'h0001, 16'(uvFaultActive));
        host.clearFault(1);
        waitN(3);
        check("clear all", 16'h0001, 16'(outputEnable));
        check("clear active", 16'h0000, 16'(uvFaultActive));
        host.writeCmd(CMD_ACTION, 16'h0041);
        voutMeasured = 16'h1000;
        waitN(4);
        voutMeasured = 16'h8000;
        waitN(20);
        check("short fault", 16'h0001, 16'(outputEnable));
        check("short active", 16'h0000, 16'(uvFaultActive));
        voutMeasured = 16'h1000;
        waitN(5);
        check("grace", 16'h0001, 16'(outputEnable));
        waitN(15);
        check("grace end", 16'h0000, 16'(outputEnable));
        voutMeasured = 16'h8000;
        host.clearFault(2);
        waitN(3);
        check("reset line", 16'h0001, 16'(outputEnable));
        for (int n = 1; n <= 7; n++) begin
            // unit and delay code both vary; code c is 2**c units
            unitNow = 2 + n % 3;
            expSpacing = unitNow << (n % 3);
            delayUnitCycles = 16'(unitNow);
            host.writeCmd(CMD_ACTION,
                          16'h0080 | 16'(n << 3) | 16'(n % 3));
            host.setOn(1'b0);
            host.setOn(1'b1);
            waitN(3);
            check("on again", 16'h0001, 16'(outputEnable));
            countClear = 1'b1;
            waitN(1);
            countClear = 1'b0;
            voutMeasured = 16'h1000;
            waitN(300);
            if (n < 7) begin
                check("restarts", 16'(n), 16'(rises));
                check("final off", 16'h0000, 16'(outputEnable));
            end else begin
                check("forever", 16'h0001, 16'(rises >= 7));
            end
            // three cycles of pipeline allowed beyond the spacing
            gapOk = (gapMin >= expSpacing && gapMax <= expSpacing + 3);
            check("spacing", 16'h0001, 16'(n == 1 || gapOk));
            host.setOn(1'b0);
            waitN(3);
            check("commanded off", 16'h0000, 16'(outputEnable));
            voutMeasured = 16'h8000;
        end
        giveVerdict;
    end
endmodule

`default_nettype wire

// ==== test/uv_host_model.sv ====
// host side model: command writes and fault clear requests
`timescale 1ns/10ps
`default_nettype none

module uv_host_model (
    input  wire logic                     clk,
    output var  uv_fault_pkg::host_write_s hostWrite,
    output var  uv_fault_pkg::clear_s      clearReq
);
    import uv_fault_pkg::*;

    initial begin
        hostWrite = '0;
        clearReq  = '0;
    end

    ////////////////////////////////////////////////////////////////////////
    // after a write the host lets go; data shows its inverse, not a stale copy
    task automatic writeCmd(input logic [7:0] cmd, input logic [15:0] data);
        @(negedge clk);
        hostWrite <= '{write: 1'b1, command: cmd, data: data};
        @(negedge clk);
        hostWrite <= '{write: 1'b0, command: ~cmd, data: ~data};
    endtask

    // kind 0 status bit, 1 clear-all, 2 reset line; one cycle wide
    task automatic clearFault(input int kind);
        @(negedge clk);
        clearReq[3-kind] <= 1'b1;
        @(negedge clk);
        clearReq[3-kind] <= 1'b0;
    endtask

    task automatic setOn(input logic on);
        @(negedge clk);
        clearReq.outputOnCmd <= on;
    endtask
endmodule

`default_nettype wire
